// >>> design/acta_pkg.sv
// Shared constants, types and tables for the ASCII command interpreter
package acta_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] REG_CMD_DATA = 8'h00;
    localparam logic [7:0] REG_REPLY_DATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CONTROL = 8'h0C;
    localparam int STS_REPLY_VALID = 0;
    localparam int STS_BUSY = 1;
    localparam int STS_NORMALIZE = 2;
    localparam int STS_MEMORY_MODE = 3;
    localparam int STS_OVERFLOW = 4;
    localparam int CTL_ENABLE = 0;
    localparam int REPLY_VALID_BIT = 8;
    localparam logic CONTROL_RESET = 1'b1;
    // ==========================================================
    // Characters and command names (four ASCII bytes)
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_SI = 8'h53;
    localparam logic [7:0] CH_ENG = 8'h45;
    localparam logic [7:0] CH_LOCK = 8'h5A;
    localparam logic [31:0] CMD_STATUS = 32'h53544154;
    localparam logic [31:0] CMD_DECODED_READ = 32'h54454452;
    localparam logic [31:0] CMD_EXTENDED_READ = 32'h4D544544;
    localparam logic [31:0] CMD_RAW_READ = 32'h54454444;
    localparam logic [31:0] CMD_NORMALIZE_ON = 32'h54454431;
    localparam logic [31:0] CMD_NORMALIZE_OFF = 32'h54454430;
    localparam logic [31:0] CMD_USER_WRITE = 32'h54454455;
    localparam logic [31:0] CMD_POSITION_WRITE = 32'h544D4944;
    localparam logic [31:0] CMD_RAW_WRITE = 32'h54454457;
    localparam logic [31:0] CMD_APP_READ = 32'h52444152;
    localparam logic [31:0] CMD_RETURN_ANALOG = 32'h544F4646;
    // ==========================================================
    // Command and sensor-memory layout
    localparam int HEADER_LEN = 9;
    localparam int USER_MAX = 13;
    localparam int RAW_BYTES = 32;
    localparam int APP_BYTES = 8;
    localparam int POS_MAX = 511;
    localparam int POS_ADDR = 17;
    localparam int USER_ADDR = 19;
    localparam logic [2:0] MODE_CHARGE = 3'h0;

    typedef enum logic [2:0] {K_ACK, K_STAT, K_DEC, K_EXT, K_RAW, K_APP} acta_kind_t;

    // Live settings reported by the status command
    typedef struct packed {
        logic [2:0] mode;      // 0 charge, others current excitation levels
        logic [2:0] low_freq;  // 0.2Hz,2Hz,med TC,long TC,S1,S10,D1,D10
        logic [2:0] low_pass;  // 0.1,1,3,10,100 kHz
        logic units_si;
        logic ref_on;
        logic overload;
        logic input_fault;
        logic long_tc_charge;
        logic clamp_held;
    } acta_sts_t;

    // One reply field: start byte, length, text or hex, trailing semicolon
    typedef struct packed {
        logic [5:0] start;
        logic [5:0] len;
        logic asc;
        logic semi;
    } acta_fld_t;

    function automatic acta_fld_t acta_field(input acta_kind_t k, input logic [3:0] f);
        acta_fld_t r;
        r = '{start: 6'h00, len: 6'h01, asc: 1'b0, semi: 1'b1};
        unique case (k)
            K_ACK: r = '{start: 6'h00, len: 6'h01, asc: 1'b1, semi: 1'b0};
            K_STAT: r = '{start: {2'h0, f}, len: 6'h01, asc: 1'b1, semi: 1'b1};
            K_RAW: r = '{start: 6'h00, len: 6'h21, asc: 1'b0, semi: 1'b0};
            K_APP: r = '{start: 6'h00, len: 6'h08, asc: 1'b0, semi: 1'b0};
            K_DEC: begin
                unique case (f)
                    4'h0: r = '{start: 6'h00, len: 6'h02, asc: 1'b0, semi: 1'b1};
                    4'h1: r = '{start: 6'h02, len: 6'h02, asc: 1'b0, semi: 1'b1};
                    4'h2: r.start = 6'h04;
                    4'h3: r.start = 6'h05;
                    4'h4: r = '{start: 6'h06, len: 6'h02, asc: 1'b0, semi: 1'b1};
                    4'h5: r.start = 6'h08;
                    4'h6: r.start = 6'h09;
                    4'h7: r.start = 6'h0A;
                    4'h8: r = '{start: 6'h11, len: 6'h02, asc: 1'b0, semi: 1'b1};
                    default: r = '{start: 6'h13, len: 6'h0D, asc: 1'b1, semi: 1'b1};
                endcase
            end
            K_EXT: r.start = 6'h0B + {2'h0, f};
            default: r = '{start: 6'h00, len: 6'h01, asc: 1'b1, semi: 1'b0};
        endcase
        return r;
    endfunction
endpackage

// >>> design/acta_core.sv
// ASCII command interpreter with sensor-memory access behind an AHB-Lite slave
`timescale 1ns/1ps
module acta_core #(
    parameter int CMD_MAX = 73,                  // Longest command body in characters
    parameter logic [23:0] VARIANT_A = 24'h564131, // Arbitrary value
    parameter logic [23:0] VARIANT_B = 24'h564132  // Arbitrary value
) (
    input wire logic CORE_CLK,                   // 100 MHz clock
    input wire logic SYS_RST,                    // Async reset, high
    input wire logic CE,                         // Clock enable
    input wire logic HSEL,                       // AHB select
    input wire logic [7:0] HADDR,                // AHB address
    input wire logic [1:0] HTRANS,               // AHB transfer type
    input wire logic HWRITE,                     // AHB write
    input wire logic [2:0] HSIZE,                // AHB size
    input wire logic [31:0] HWDATA,              // AHB write data
    input wire logic HREADY,                     // AHB bus ready
    output logic [31:0] HRDATA,                  // AHB read data
    output logic HREADYOUT,                      // AHB slave ready
    output logic HRESP,                          // AHB response
    input wire logic [1:0] RACK_ID,              // Own rack position
    input wire logic [2:0] SLOT_ID,              // Own slot position
    input wire logic VARIANT_SEL,                // Own module variant
    input wire acta_pkg::acta_sts_t STATUS_IN,   // Live settings
    input wire logic [63:0] APP_REG,             // Locked application register
    input wire logic [63:0] APP_SCRATCH,         // Application scratchpad
    input wire logic APP_LOCKED,                 // Application register locked
    output logic NORMALIZE_EN,                   // Auto normalization on
    output logic MEMORY_MODE,                    // Sensor-memory mode
    output logic EXCITATION_EN                   // Sensor excitation on
);
    typedef enum {G_IDLE, G_DATA, G_SEMI, G_CR} acta_gen_t;

    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            return {1'b1, c[3:0]};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            return {1'b1, c[3:0] + 4'h9};
        end
        return 5'h00;
    endfunction

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        return (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    endfunction

    // ==========================================================
    // AHB-Lite slave
    logic [7:0] cmd_buf [CMD_MAX];
    logic [6:0] cmd_cnt;
    logic overflow;
    logic exec;
    logic enable;
    logic [7:0] tx_char;
    logic tx_valid;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic busy;
    logic take;
    acta_gen_t gen;

    assign take = HSEL && HTRANS[1] && HREADY;
    assign busy = exec || (gen != G_IDLE);

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (CE) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend <= take && HWRITE;
            if (take) begin
                wr_addr <= HADDR;
            end
            HRDATA <= 32'h00000000;
            if (take && !HWRITE) begin
                unique case (HADDR)
                    acta_pkg::REG_REPLY_DATA: HRDATA <= {23'h000000, tx_valid, tx_char};
                    acta_pkg::REG_STATUS: HRDATA <= {27'h0000000, overflow, MEMORY_MODE,
                                                     NORMALIZE_EN, busy, tx_valid};
                    acta_pkg::REG_CONTROL: HRDATA <= {31'h00000000, enable};
                    default: HRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            enable <= acta_pkg::CONTROL_RESET;
        end else if (CE && wr_pend && wr_addr == acta_pkg::REG_CONTROL) begin
            enable <= HWDATA[acta_pkg::CTL_ENABLE];
        end
    end

    // ==========================================================
    // Command line assembly; carriage return ends a command
    logic push;
    assign push = wr_pend && wr_addr == acta_pkg::REG_CMD_DATA && enable && !busy;

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_cnt <= 7'h00;
            overflow <= 1'b0;
            exec <= 1'b0;
            for (int i = 0; i < CMD_MAX; i++) begin
                cmd_buf[i] <= 8'h00;
            end
        end else if (CE) begin
            exec <= push && HWDATA[7:0] == acta_pkg::CH_CR && !overflow;
            if (exec) begin
                cmd_cnt <= 7'h00;
            end else if (push && HWDATA[7:0] == acta_pkg::CH_CR) begin
                overflow <= 1'b0;
                if (overflow) begin
                    cmd_cnt <= 7'h00;
                end
            end else if (push && cmd_cnt == 7'(CMD_MAX)) begin
                overflow <= 1'b1;
            end else if (push) begin
                cmd_buf[cmd_cnt] <= HWDATA[7:0];
                cmd_cnt <= cmd_cnt + 7'h01;
            end
        end
    end

    // ==========================================================
    // Decode
    logic addressed;
    logic [31:0] name;
    logic [6:0] arg_len;
    logic raw_ok;
    logic pos_ok;
    logic [9:0] pos_val;
    logic [4:0] hv;

    always_comb begin
        addressed = cmd_cnt >= 7'(acta_pkg::HEADER_LEN)
            && cmd_buf[0] == {6'h0C, RACK_ID}
            && cmd_buf[1] == {5'h06, SLOT_ID}
            && {cmd_buf[2], cmd_buf[3], cmd_buf[4]} == (VARIANT_SEL ? VARIANT_B : VARIANT_A);
        name = {cmd_buf[5], cmd_buf[6], cmd_buf[7], cmd_buf[8]};
        arg_len = cmd_cnt - 7'(acta_pkg::HEADER_LEN);
        raw_ok = arg_len == 7'(2 * acta_pkg::RAW_BYTES);
        for (int i = 0; i < 2 * acta_pkg::RAW_BYTES; i++) begin
            hv = hex_val(cmd_buf[acta_pkg::HEADER_LEN + i]);
            raw_ok = raw_ok && hv[4];
        end
        pos_ok = arg_len >= 7'h01 && arg_len <= 7'h03;
        pos_val = 10'h000;
        for (int i = 0; i < 3; i++) begin
            if (7'(i) < arg_len) begin
                hv = hex_val(cmd_buf[acta_pkg::HEADER_LEN + i]);
                pos_ok = pos_ok && hv[4] && hv[3:0] <= 4'h9;
                pos_val = 10'(pos_val * 10'd10) + {6'h00, hv[3:0]};
            end
        end
        pos_ok = pos_ok && pos_val <= 10'(acta_pkg::POS_MAX);
        hv = 5'h00;
    end

    logic run;
    assign run = exec && addressed;

    // ==========================================================
    // Sensor memory contents and writes
    logic [7:0] mem [acta_pkg::RAW_BYTES];
    logic [7:0] checksum;

    always_comb begin
        checksum = 8'h00;
        for (int i = 0; i < acta_pkg::RAW_BYTES; i++) begin
            checksum = checksum + mem[i];
        end
        checksum = 8'h00 - checksum;
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < acta_pkg::RAW_BYTES; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (CE && run) begin
            if (name == acta_pkg::CMD_RAW_WRITE && raw_ok) begin
                for (int i = 0; i < acta_pkg::RAW_BYTES; i++) begin
                    mem[i] <= {cmd_buf[acta_pkg::HEADER_LEN + 2 * i][3:0]
                               + (cmd_buf[acta_pkg::HEADER_LEN + 2 * i][6] ? 4'h9 : 4'h0),
                               cmd_buf[acta_pkg::HEADER_LEN + 2 * i + 1][3:0]
                               + (cmd_buf[acta_pkg::HEADER_LEN + 2 * i + 1][6] ? 4'h9 : 4'h0)};
                end
            end
            if (name == acta_pkg::CMD_USER_WRITE && arg_len <= 7'(acta_pkg::USER_MAX)) begin
                for (int i = 0; i < acta_pkg::USER_MAX; i++) begin
                    mem[acta_pkg::USER_ADDR + i] <= (7'(i) < arg_len)
                        ? cmd_buf[acta_pkg::HEADER_LEN + i] : acta_pkg::CH_SPACE;
                end
            end
            if (name == acta_pkg::CMD_POSITION_WRITE && pos_ok) begin
                mem[acta_pkg::POS_ADDR] <= {7'h00, pos_val[8]};
                mem[acta_pkg::POS_ADDR + 1] <= pos_val[7:0];
            end
        end
    end

    // ==========================================================
    // Mode flags
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            NORMALIZE_EN <= 1'b0;
        end else if (CE && run && name == acta_pkg::CMD_NORMALIZE_ON) begin
            NORMALIZE_EN <= 1'b1;
        end else if (CE && run && name == acta_pkg::CMD_NORMALIZE_OFF) begin
            NORMALIZE_EN <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MEMORY_MODE <= 1'b0;
            EXCITATION_EN <= 1'b1;
        end else if (CE && run && name == acta_pkg::CMD_APP_READ) begin
            MEMORY_MODE <= 1'b1;
            EXCITATION_EN <= 1'b0;
        end else if (CE && run && name == acta_pkg::CMD_RETURN_ANALOG) begin
            MEMORY_MODE <= 1'b0;
            EXCITATION_EN <= 1'b1;
        end
    end

    // ==========================================================
    // Status snapshot, packed so that absent fields leave no gap
    logic [7:0] stat_next [8];
    logic [3:0] stat_n_next;
    logic [7:0] stat_buf [8];
    logic [3:0] stat_n;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            stat_next[i] = 8'h00;
        end
        stat_next[0] = {5'h06, STATUS_IN.mode};
        stat_next[1] = {5'h06, STATUS_IN.low_freq};
        stat_next[2] = {5'h06, STATUS_IN.low_pass};
        stat_next[3] = STATUS_IN.units_si ? acta_pkg::CH_SI : acta_pkg::CH_ENG;
        stat_next[4] = {7'h18, STATUS_IN.ref_on};
        stat_next[5] = {7'h18, STATUS_IN.overload};
        stat_n_next = 4'h6;
        if (STATUS_IN.mode != acta_pkg::MODE_CHARGE) begin
            stat_next[6] = {7'h18, STATUS_IN.input_fault};
            stat_n_next = 4'h7;
        end
        if (STATUS_IN.long_tc_charge && STATUS_IN.clamp_held) begin
            stat_next[stat_n_next[2:0]] = acta_pkg::CH_LOCK;
            stat_n_next = stat_n_next + 4'h1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stat_n <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                stat_buf[i] <= 8'h00;
            end
        end else if (CE && run && name == acta_pkg::CMD_STATUS) begin
            stat_n <= stat_n_next;
            stat_buf <= stat_next;
        end
    end

    // ==========================================================
    // Reply generator
    acta_pkg::acta_kind_t kind;
    acta_pkg::acta_kind_t next_kind;
    logic reply;
    logic [3:0] fld;
    logic [5:0] pos;
    logic nib;
    logic [3:0] nfld;
    acta_pkg::acta_fld_t fi;
    logic [5:0] addr;
    logic [7:0] src;
    logic [7:0] chr;

    always_comb begin
        reply = 1'b1;
        next_kind = acta_pkg::K_ACK;
        unique case (name)
            acta_pkg::CMD_STATUS: next_kind = acta_pkg::K_STAT;
            acta_pkg::CMD_DECODED_READ: next_kind = acta_pkg::K_DEC;
            acta_pkg::CMD_EXTENDED_READ: next_kind = acta_pkg::K_EXT;
            acta_pkg::CMD_RAW_READ: next_kind = acta_pkg::K_RAW;
            acta_pkg::CMD_APP_READ: next_kind = acta_pkg::K_APP;
            acta_pkg::CMD_NORMALIZE_ON, acta_pkg::CMD_NORMALIZE_OFF, acta_pkg::CMD_USER_WRITE,
            acta_pkg::CMD_POSITION_WRITE, acta_pkg::CMD_RAW_WRITE,
            acta_pkg::CMD_RETURN_ANALOG: next_kind = acta_pkg::K_ACK;
            default: reply = 1'b0;
        endcase
    end

    always_comb begin
        unique case (kind)
            acta_pkg::K_STAT: nfld = stat_n;
            acta_pkg::K_DEC: nfld = 4'hA;
            acta_pkg::K_EXT: nfld = 4'h6;
            default: nfld = 4'h1;
        endcase
        fi = acta_pkg::acta_field(kind, fld);
        addr = fi.start + pos;
        unique case (kind)
            acta_pkg::K_ACK: src = acta_pkg::CH_ZERO;
            acta_pkg::K_STAT: src = stat_buf[addr[2:0]];
            acta_pkg::K_APP: src = APP_LOCKED ? APP_REG[8 * (7 - addr[2:0]) +: 8]
                                              : APP_SCRATCH[8 * (7 - addr[2:0]) +: 8];
            acta_pkg::K_RAW: src = (addr == 6'h00) ? checksum : mem[5'(addr - 6'h01)];
            default: src = mem[addr[4:0]];
        endcase
        chr = fi.asc ? src : hex_chr(nib ? src[3:0] : src[7:4]);
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gen <= G_IDLE;
            kind <= acta_pkg::K_ACK;
            fld <= 4'h0;
            pos <= 6'h00;
            nib <= 1'b0;
            tx_valid <= 1'b0;
            tx_char <= 8'h00;
        end else if (CE) begin
            if (take && !HWRITE && HADDR == acta_pkg::REG_REPLY_DATA) begin
                tx_valid <= 1'b0;
            end
            if (run && reply) begin
                gen <= G_DATA;
                kind <= next_kind;
                fld <= 4'h0;
                pos <= 6'h00;
                nib <= 1'b0;
            end else if (gen != G_IDLE && !tx_valid) begin
                tx_valid <= 1'b1;
                unique case (gen)
                    G_DATA: begin
                        tx_char <= chr;
                        nib <= !nib && !fi.asc;
                        if ((fi.asc || nib) && pos == fi.len - 6'h01) begin
                            pos <= 6'h00;
                            if (fi.semi) begin
                                gen <= G_SEMI;
                            end else if (fld == nfld - 4'h1) begin
                                gen <= G_CR;
                            end else begin
                                fld <= fld + 4'h1;
                            end
                        end else if (fi.asc || nib) begin
                            pos <= pos + 6'h01;
                        end
                    end
                    G_SEMI: begin
                        tx_char <= acta_pkg::CH_SEMI;
                        if (fld == nfld - 4'h1) begin
                            gen <= G_CR;
                        end else begin
                            fld <= fld + 4'h1;
                            gen <= G_DATA;
                        end
                    end
                    G_CR: begin
                        tx_char <= acta_pkg::CH_CR;
                        gen <= G_IDLE;
                    end
                    default: gen <= G_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> bench/acta_core_properties.sv
// Concurrent checks on the interpreter's bus and mode outputs
`timescale 1ns/1ps
module acta_core_properties (
    input wire logic CORE_CLK, // clock
    input wire logic SYS_RST, // reset
    input wire logic HSEL, // select
    input wire logic [7:0] HADDR, // address
    input wire logic [1:0] HTRANS, // transfer
    input wire logic HWRITE, // write
    input wire logic [31:0] HWDATA, // wdata
    input wire logic HREADY, // ready in
    input wire logic [31:0] HRDATA, // rdata
    input wire logic HREADYOUT, // ready out
    input wire logic HRESP, // response
    input wire logic NORMALIZE_EN, // normalize
    input wire logic MEMORY_MODE, // memory mode
    input wire logic EXCITATION_EN // excitation
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    logic rd;
    assign rd = HSEL && HTRANS[1] && HREADY && !HWRITE;
    // ==========================================================
    // Properties
    property p_rdy; HREADYOUT; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state inserted");
    property p_okay; !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_exc; EXCITATION_EN == !MEMORY_MODE; endproperty
    a_exc: assert property (p_exc) else $error("excitation in memory mode");
    property p_idle; !rd |=> HRDATA == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_hi; HRDATA[31:9] == 23'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_sts; rd && HADDR == acta_pkg::REG_STATUS |=> HRDATA[3] == $past(MEMORY_MODE) &&
        HRDATA[2] == $past(NORMALIZE_EN); endproperty
    a_sts: assert property (p_sts) else $error("status bits wrong");
    property p_norm; $changed(NORMALIZE_EN) |-> $past(HWDATA[7:0], 2) == acta_pkg::CH_CR; endproperty
    a_norm: assert property (p_norm) else $error("normalize moved outside command");
    property p_mem; $changed(MEMORY_MODE) |-> $past(HWDATA[7:0], 2) == acta_pkg::CH_CR; endproperty
    a_mem: assert property (p_mem) else $error("memory mode moved outside command");
endmodule
bind acta_core acta_core_properties u_chk (.CORE_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .NORMALIZE_EN, .MEMORY_MODE, .EXCITATION_EN);

// >>> bench/acta_host.sv
// Host-side bus master that writes command characters and polls replies
`timescale 1ns/1ps
module acta_host (
    input wire logic clk, // bus clock
    input wire logic hready, // slave ready
    input wire logic [31:0] hrdata, // read data
    output logic hsel, // select
    output logic [7:0] haddr, // address
    output logic [1:0] htrans, // transfer
    output logic hwrite, // write
    output logic [31:0] hwdata // write data
);
    initial {hsel, htrans, hwrite, haddr, hwdata} = 44'h0;
    // One single word transfer; write data is held until the next write
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        do @(posedge clk); while (!hready);
        {hsel, htrans} <= 3'h0;
        if (w) hwdata <= d;
        do @(posedge clk); while (!hready);
        q = hrdata;
    endtask
endmodule

// >>> bench/tb_ascii_cmd_status_teds_access.sv
// Self-checking bench for the ASCII command interpreter
`timescale 1ns/1ps
module tb_ascii_cmd_status_teds_access;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel, hwrite, hready, hresp, norm, mem, exc;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata;
    logic [127:0] r;
    acta_pkg::acta_sts_t sts = 15'h0000;
    logic locked = 1'b0;
    logic variant = 1'b0;
    logic [63:0] app_reg = 64'hFEDCBA9876543210;
    logic [63:0] app_scr = 64'h0123456789ABCDEF;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    acta_host u_host (.clk(core_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
    acta_core u_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .RACK_ID(2'h1), .SLOT_ID(3'h2), .VARIANT_SEL(variant),
        .STATUS_IN(sts), .APP_REG(app_reg), .APP_SCRATCH(app_scr),
        .APP_LOCKED(locked), .NORMALIZE_EN(norm), .MEMORY_MODE(mem), .EXCITATION_EN(exc));
    task check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t mismatch %h vs %h", $time, seen, exp);
        end
    endtask
    task send(input string s);
        logic [31:0] q;
        for (int i = 0; i < s.len(); i++) u_host.xfer(1'b1, acta_pkg::REG_CMD_DATA, {24'h0, s[i]}, q);
        u_host.xfer(1'b1, acta_pkg::REG_CMD_DATA, {24'h0, acta_pkg::CH_CR}, q);
    endtask
    // Collects reply characters up to the closing CR, bounded poll count
    task get(output logic [127:0] rep);
        logic [31:0] q;
        rep = 128'h0;
        for (int n = 0; n < 300; n++) begin
            u_host.xfer(1'b0, acta_pkg::REG_REPLY_DATA, 32'h0, q);
            if (q[8] === 1'b1 && q[7:0] === acta_pkg::CH_CR) break;
            if (q[8] === 1'b1) rep = {rep[119:0], q[7:0]};
        end
    endtask
    task t_stat();
        sts <= 15'b001_101_011_1_0_1_0_0_0;
        send("12VA1STAT");
        get(r);
        check(r, "1;5;3;S;0;1;0;");
        sts <= 15'b000_011_000_0_1_0_0_1_1;
        send("12VA1STAT");
        get(r);
        check(r, "0;3;0;E;1;0;Z;");
        $display("status test done");
    endtask
    task t_norm();
        send("12VA1TED1");
        get(r);
        check(r, "0");
        check({127'h0, norm}, 128'h1);
        send("12VA1TED0");
        get(r);
        check({r[119:0], 7'h0, norm}, {"0", 8'h0});
        $display("normalize test done");
    endtask
    task t_mem();
        send("12VA1TEDW000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F");
        get(r);
        check(r, "0");
        send("12VA1TEDD");
        get(r);
        check(r, "18191A1B1C1D1E1F");
        send("12VA1MTED");
        get(r);
        check(r, ";0C;0D;0E;0F;10;");
        send("12VA1TEDUHELLO");
        get(r);
        check(r, "0");
        send("12VA1TMID300");
        get(r);
        check(r, "0");
        send("12VA1TEDR");
        get(r);
        check(r, "C;HELLO        ;");
        $display("memory test done");
    endtask
    task t_app();
        logic [31:0] q;
        send("12VA1RDAR");
        get(r);
        check(r, "0123456789ABCDEF");
        check({126'h0, mem, exc}, 128'h2);
        u_host.xfer(1'b0, acta_pkg::REG_STATUS, 32'h0, q);
        check({96'h0, q}, 128'h8);
        locked <= 1'b1;
        send("12VA1RDAR");
        get(r);
        check(r, "FEDCBA9876543210");
        send("12VA1TOFF");
        get(r);
        check({r[119:0], 6'h0, mem, exc}, {"0", 8'h1});
        $display("app register test done");
    endtask
    task t_miss();
        send("13VA1TED1");
        get(r);
        check(r, 128'h0);
        send("12VA2TED1");
        get(r);
        check({r[126:0], norm}, 128'h0);
        variant <= 1'b1;
        send("12VA2TED1");
        get(r);
        check({r[119:0], 7'h0, norm}, {"0", 8'h1});
        $display("mismatch test done");
    endtask
    task finish_test();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_stat();
        t_norm();
        t_mem();
        t_app();
        t_miss();
        finish_test();
    end
endmodule
